/* bbi_ctrl.sv */
// Backplane bus reply watchdog, transceiver steering and chain logic.
// Operation
// - Read/write request arms ten microsecond window
// - Stall processor with slips awaiting reply
// - Reply raises reply_received and stall release
// - Fifty slips without reply set timeout
// - Row strobe clears the timeout flag unless the watchdog stays in or enters done
// - Timeout flag drives the halt logic
// - Stall release ends slips and clock stop
// - Synchronised reply (sync_reply_o) enables external read capture
// - Transmit for local cycles and external writes
// - Bus clear low disables all transceivers
// - Acknowledge: high byte off, low receives
// - Receive overrides transmit whenever enabled
// - External read with reply receives both bytes
// - DMA before read strobe: receive address
// - DMA read local transmits, write receives
// - I/O page select when top bits high
// - Only level four interrupt request accepted
// - DMA lowest priority, blocks interrupts while owned
// - Forward acknowledge and grant down chain
// - Master aborts cycle after ten microseconds
// - Timeout longer than slowest slave reply
// - Local accesses drive strobes like external
`timescale 1ns/1ps
module bbi_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = bbi_pkg::TIMEOUT_CYCLES,
  parameter int unsigned TIMEOUT_SLIPS = bbi_pkg::TIMEOUT_SLIPS
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic read_strobe_request_i,
  input wire logic write_strobe_request_i,
  input wire logic slave_reply_n_i,
  input wire logic row_strobe_i,
  input wire logic bus_clear_n_i,
  input wire logic intr_ack_n_i,
  input wire logic external_select_n_i,
  input wire logic read_indication_i,
  input wire logic dma_grant_active_i,
  input wire logic bus_cycle_frame_n_i,
  input wire logic bus_read_strobe_n_i,
  input wire logic bus_write_strobe_n_i,
  input wire logic proc_cycle_type_hi_i,
  input wire logic [15:0] local_data_addr_bus_i,
  input wire logic intr_request_level4_n_i,
  input wire logic intr_request_level5_n_i,
  input wire logic intr_request_level6_n_i,
  input wire logic intr_request_level7_n_i,
  input wire logic dma_request_line_n_i,
  input wire logic intr_ack_chain_in_n_i,
  input wire logic dma_grant_chain_in_n_i,
  input wire logic own_intr_pending_i,
  input wire logic own_dma_pending_i,
  output logic timeout_flag_o,
  output logic stall_release_n_o,
  output logic reply_received_o,
  output logic slip_o,
  output logic sync_reply_o,
  output logic tx_lo_en_o,
  output logic tx_hi_en_o,
  output logic rx_lo_en_o,
  output logic rx_hi_en_o,
  output logic io_page_select_n_o,
  output logic io_page_select_rx_o,
  output logic intr_req_o,
  output logic dma_req_o,
  output logic intr_ack_chain_out_n_o,
  output logic dma_grant_chain_out_n_o
);
  // Fewer cycles than slips would leave the divider nothing to count.
  if (TIMEOUT_SLIPS < 1 || TIMEOUT_CYCLES < TIMEOUT_SLIPS)
  begin : g_bad_timeout
    $error("Timeout must hold at least one cycle per slip.");
  end
  bbi_slip_if sif ();
  bbi_pkg::bbi_state_t st_reg, st_next;
  logic tmo_reg, tmo_next;
  logic rrp_reg, rrp_next;
  logic srn_reg, srn_next;
  logic slip_reg, slip_next;
  logic srep_reg, srep_next;
  logic req_start;
  bbi_slip_div #(
    .CYCLES(TIMEOUT_CYCLES),
    .SLIPS(TIMEOUT_SLIPS)
  ) u_div (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .s(sif.div)
  );
  // Either strobe request opens a window; slips run only while waiting.
  assign req_start = read_strobe_request_i | write_strobe_request_i;
  assign sif.run = (st_reg == bbi_pkg::BBI_WAIT);
  // Watchdog: arm on request, wait for reply or fifty slips.
  always_comb
  begin
    st_next = st_reg;
    tmo_next = tmo_reg;
    rrp_next = !slave_reply_n_i;
    srep_next = !slave_reply_n_i & rrp_reg;
    slip_next = 1'b0;
    srn_next = 1'b1;
    unique case (st_reg)
      bbi_pkg::BBI_IDLE:
      begin
        if (req_start)
        begin
          st_next = bbi_pkg::BBI_WAIT;
        end
      end
      bbi_pkg::BBI_WAIT:
      begin
        slip_next = sif.slip;
        if (!slave_reply_n_i)
        begin
          st_next = bbi_pkg::BBI_DONE;
          srn_next = 1'b0;
        end
        else if (sif.expired)
        begin
          st_next = bbi_pkg::BBI_DONE;
          tmo_next = 1'b1;
          srn_next = 1'b0;
        end
      end
      bbi_pkg::BBI_DONE:
      begin
        srn_next = 1'b0;
        if (!req_start)
        begin
          st_next = bbi_pkg::BBI_IDLE;
        end
      end
      default:
      begin
        st_next = bbi_pkg::BBI_IDLE;
      end
    endcase
    // Clear only on row strobe, so the halt logic sees a steady level.
    if (row_strobe_i && st_next != bbi_pkg::BBI_DONE)
    begin
      tmo_next = 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= bbi_pkg::BBI_IDLE;
      tmo_reg <= 1'b0;
      rrp_reg <= 1'b0;
      srn_reg <= 1'b1;
      slip_reg <= 1'b0;
      srep_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      tmo_reg <= tmo_next;
      rrp_reg <= rrp_next;
      srn_reg <= srn_next;
      slip_reg <= slip_next;
      srep_reg <= srep_next;
    end
  end
  logic txl_reg, txl_next;
  logic txh_reg, txh_next;
  logic rxl_reg, rxl_next;
  logic rxh_reg, rxh_next;
  logic iop_reg, iop_next;
  logic iopr_reg, iopr_next;
  logic irq_reg, irq_next;
  logic dmr_reg, dmr_next;
  logic iako_reg, iako_next;
  logic dmgo_reg, dmgo_next;
  // Transceiver steering; receive wins over transmit when both enable.
  always_comb
  begin
    logic rx_both;
    logic rx_lo;
    logic tx;
    rx_both = 1'b0;
    rx_lo = 1'b0;
    tx = 1'b0;
    if (dma_grant_active_i)
    begin
      if (bus_cycle_frame_n_i || bus_read_strobe_n_i)
        rx_both = 1'b1;
      if (!bus_write_strobe_n_i)
        rx_both = 1'b1;
      else if (!bus_read_strobe_n_i && external_select_n_i)
        tx = 1'b1;
    end
    else
    begin
      // Strobes go out on local and external cycles alike.
      tx = 1'b1;
      if (!external_select_n_i && read_indication_i && srep_reg)
      begin
        rx_both = 1'b1;
      end
      if (!intr_ack_n_i)
      begin
        rx_lo = 1'b1;
      end
    end
    rxl_next = rx_both | rx_lo;
    rxh_next = rx_both & intr_ack_n_i;
    txl_next = tx & !rxl_next;
    txh_next = tx & !rxh_next & intr_ack_n_i;
    if (!bus_clear_n_i)
    begin
      rxl_next = 1'b0;
      rxh_next = 1'b0;
      txl_next = 1'b0;
      txh_next = 1'b0;
    end
    iop_next = !(&local_data_addr_bus_i[bbi_pkg::ADDR_W-1:
      bbi_pkg::IOPAGE_LSB] && !proc_cycle_type_hi_i);
    irq_next = !intr_request_level4_n_i & !dma_grant_active_i;
    dmr_next = !dma_request_line_n_i;
    iako_next = intr_ack_chain_in_n_i | own_intr_pending_i;
    dmgo_next = dma_grant_chain_in_n_i | own_dma_pending_i;
    iopr_next = !iop_next;
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      txl_reg <= 1'b0;
      txh_reg <= 1'b0;
      rxl_reg <= 1'b0;
      rxh_reg <= 1'b0;
      iop_reg <= 1'b1;
      iopr_reg <= 1'b0;
      irq_reg <= 1'b0;
      dmr_reg <= 1'b0;
      iako_reg <= 1'b1;
      dmgo_reg <= 1'b1;
    end
    else
    begin
      txl_reg <= txl_next;
      txh_reg <= txh_next;
      rxl_reg <= rxl_next;
      rxh_reg <= rxh_next;
      iop_reg <= iop_next;
      iopr_reg <= iopr_next;
      irq_reg <= irq_next;
      dmr_reg <= dmr_next;
      iako_reg <= iako_next;
      dmgo_reg <= dmgo_next;
    end
  end
  assign timeout_flag_o = tmo_reg;
  assign stall_release_n_o = srn_reg;
  assign reply_received_o = rrp_reg;
  assign slip_o = slip_reg;
  assign sync_reply_o = srep_reg;
  assign tx_lo_en_o = txl_reg;
  assign tx_hi_en_o = txh_reg;
  assign rx_lo_en_o = rxl_reg;
  assign rx_hi_en_o = rxh_reg;
  assign io_page_select_n_o = iop_reg;
  assign io_page_select_rx_o = iopr_reg;
  assign intr_req_o = irq_reg;
  assign dma_req_o = dmr_reg;
  assign intr_ack_chain_out_n_o = iako_reg;
  assign dma_grant_chain_out_n_o = dmgo_reg;
  property p_timeout_set;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_reg == bbi_pkg::BBI_WAIT && slave_reply_n_i && sif.expired)
      |=> timeout_flag_o && !stall_release_n_o;
  endproperty
  a_timeout_set: assert property (p_timeout_set)
    else $error("Timeout not raised after window expired.");
  property p_reply_release;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_reg == bbi_pkg::BBI_WAIT && !slave_reply_n_i && !tmo_reg)
      |=> !stall_release_n_o && !timeout_flag_o;
  endproperty
  a_reply_release: assert property (p_reply_release)
    else $error("Reply did not release stall cleanly.");
  property p_arm;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_reg == bbi_pkg::BBI_IDLE && req_start) |=> sif.run;
  endproperty
  a_arm: assert property (p_arm)
    else $error("Watchdog not armed by request.");
  property p_stall;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_reg == bbi_pkg::BBI_WAIT && slave_reply_n_i && !sif.expired)
      |=> stall_release_n_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Stall released while waiting.");
  property p_hold;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (timeout_flag_o && !row_strobe_i) |=> timeout_flag_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Timeout flag dropped without row strobe.");
  property p_clear_off;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !bus_clear_n_i |=> !(tx_lo_en_o | tx_hi_en_o | rx_lo_en_o | rx_hi_en_o);
  endproperty
  a_clear_off: assert property (p_clear_off)
    else $error("Transceivers enabled under bus clear.");
  property p_rx_wins;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !(rx_lo_en_o && tx_lo_en_o) && !(rx_hi_en_o && tx_hi_en_o);
  endproperty
  a_rx_wins: assert property (p_rx_wins)
    else $error("Receive and transmit both enabled on a lane.");
  property p_iak;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (!intr_ack_n_i && bus_clear_n_i && !dma_grant_active_i)
      |=> rx_lo_en_o && !rx_hi_en_o && !tx_hi_en_o;
  endproperty
  a_iak: assert property (p_iak)
    else $error("Acknowledge lane steering wrong.");
  property p_iopage;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (&local_data_addr_bus_i[15:13] && !proc_cycle_type_hi_i)
      |=> !io_page_select_n_o;
  endproperty
  a_iopage: assert property (p_iopage)
    else $error("I/O page select missing.");
  c_reply: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    st_reg == bbi_pkg::BBI_WAIT && !slave_reply_n_i);
  c_timeout: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(timeout_flag_o));
  c_dma_rx: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    dma_grant_active_i && rx_hi_en_o);
endmodule // bbi_ctrl

/* bbi_pkg.sv */
// Package with constants and types for the backplane bus interface control.
package bbi_pkg;
  // Reply timeout window in nanoseconds.
  localparam int unsigned TIMEOUT_NS = 10000;
  // Clock period in nanoseconds at 20 MHz.
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Longest wait rounds down to whole cycles.
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
  // Cycle slips in one timeout window.
  localparam int unsigned TIMEOUT_SLIPS = 50;
  // Address bits that mark the I/O page.
  localparam int unsigned IOPAGE_LSB = 13;
  localparam int unsigned ADDR_W = 16;
  localparam logic [2:0] IOPAGE_TAG = 3'h7;
  // Reply watchdog states, one-hot.
  typedef enum logic [2:0] {
    BBI_IDLE = 3'h1,
    BBI_WAIT = 3'h2,
    BBI_DONE = 3'h4
  } bbi_state_t;
endpackage

/* bbi_slip_if.sv */
// Interface carrying slip enable, slip pulse and expiry between watchdog and divider.
`timescale 1ns/1ps
interface bbi_slip_if;
  logic run;
  logic slip;
  logic expired;
  modport ctl (output run, input slip, input expired);
  modport div (input run, output slip, output expired);
endinterface

/* bbi_slip_div.sv */
// Cycle slip divider and slip counter for the reply watchdog.
`timescale 1ns/1ps
module bbi_slip_div #(
  parameter int unsigned CYCLES = 200,
  parameter int unsigned SLIPS = 50
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  bbi_slip_if.div s
);
  localparam int unsigned PER = CYCLES / SLIPS;
  localparam int unsigned PW = $clog2(PER + 1);
  localparam int unsigned SW = $clog2(SLIPS + 1);
  localparam logic [PW-1:0] PER_LAST = PW'(PER - 1);
  localparam logic [SW-1:0] SLIP_LAST = SW'(SLIPS);

  // A zero period would never pulse, so the watchdog would never expire.
  if (PER < 1 || SLIPS < 1)
  begin : g_bad_div
    $error("Slip divider needs at least one cycle per slip.");
  end

  logic [PW-1:0] div_reg;
  logic [PW-1:0] div_next;
  logic [SW-1:0] cnt_reg;
  logic [SW-1:0] cnt_next;
  logic slip_reg;
  logic slip_next;

  // Divide the clock into slip pulses while the watchdog runs.
  always_comb
  begin
    div_next = div_reg;
    cnt_next = cnt_reg;
    slip_next = 1'b0;
    if (!s.run)
    begin
      div_next = '0;
      cnt_next = '0;
    end
    else if (div_reg == PER_LAST)
    begin
      div_next = '0;
      slip_next = 1'b1;
      if (cnt_reg != SLIP_LAST)
      begin
        cnt_next = cnt_reg + SW'(1);
      end
    end
    else
    begin
      div_next = div_reg + PW'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_reg <= '0;
      cnt_reg <= '0;
      slip_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      slip_reg <= slip_next;
    end
  end

  assign s.slip = slip_reg;
  assign s.expired = (cnt_reg == SLIP_LAST);
endmodule // bbi_slip_div

/* bbi_slave_model.sv */
// Behavioural model of a backplane slave answering the reply watchdog.
`timescale 1ns/1ps
module bbi_slave_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic read_strobe_request_i,
  input wire logic write_strobe_request_i,
  input wire logic [7:0] delay_i,
  input wire logic mute_i,
  output logic slave_reply_n_o
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic req;

  // Count cycles of the open request; a mute slave never answers.
  assign req = read_strobe_request_i | write_strobe_request_i;
  always_comb
  begin
    cnt_next = cnt_reg;
    if (!req)
      cnt_next = 8'h00;
    else if (cnt_reg != 8'hFF)
      cnt_next = cnt_reg + 8'h01;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end

  // The line is terminated, so a released reply reads negated high.
  assign slave_reply_n_o = !(req && !mute_i && cnt_reg >= delay_i);
endmodule // bbi_slave_model

/* testbench.sv */
// Self-checking bench for the backplane bus interface control.
`timescale 1ns/1ps
module testbench;
  localparam int unsigned TOC = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic row = 1'b0;
  logic m_mute = 1'b0;
  logic [7:0] m_dly = 8'h01;
  logic [12:0] st = 13'h1ECE;
  logic reply_n, flag, srel_n, rrcv, slip, syncr, io_rx, dreq;
  logic [7:0] got;
  int n_mismatch = 0;
  int cmp_count = 0;
  int slips = 0;
  int cyc;
  // Steering rows: inputs in the upper field, expected enables below.
  logic [20:0] rows [13] = '{
    {13'h1ECE, 8'hCB}, {13'h0ECE, 8'h0B}, {13'h18CE, 8'hCB},
    {13'h16CE, 8'h2B}, {13'h1EDE, 8'hC3}, {13'h1EC6, 8'hCF},
    {13'h1ECA, 8'hCB}, {13'h1BCE, 8'h3B}, {13'h1F4E, 8'hCB},
    {13'h1D8E, 8'h3B}, {13'h1BC6, 8'h3B}, {13'h1ECC, 8'hC8},
    {13'h1ECD, 8'hCB}};

  always #25 clk = ~clk;

  bbi_slave_model i_bbi_slave_model (
    .ref_clk_i(clk), .rstn_i(rstn), .read_strobe_request_i(rd_req),
    .write_strobe_request_i(wr_req), .delay_i(m_dly), .mute_i(m_mute),
    .slave_reply_n_o(reply_n));

  // Short counts keep the timeout scenario brief.
  bbi_ctrl #(.TIMEOUT_CYCLES(TOC), .TIMEOUT_SLIPS(2)) i_bbi_ctrl (
    .ref_clk_i(clk), .rstn_i(rstn), .read_strobe_request_i(rd_req),
    .write_strobe_request_i(wr_req), .slave_reply_n_i(reply_n),
    .row_strobe_i(row), .bus_clear_n_i(st[12]), .intr_ack_n_i(st[11]),
    .external_select_n_i(st[10]), .read_indication_i(st[9]),
    .dma_grant_active_i(st[8]), .bus_cycle_frame_n_i(st[7] & st[6]),
    .bus_read_strobe_n_i(st[7]), .bus_write_strobe_n_i(st[6]),
    .proc_cycle_type_hi_i(st[5]),
    .local_data_addr_bus_i({{3{st[4]}}, 13'h0ABC}),
    .intr_request_level4_n_i(st[3]), .intr_request_level5_n_i(st[2]),
    .intr_request_level6_n_i(st[2]), .intr_request_level7_n_i(st[2]),
    .dma_request_line_n_i(st[2]), .intr_ack_chain_in_n_i(st[1]),
    .dma_grant_chain_in_n_i(st[1]), .own_intr_pending_i(st[0]),
    .own_dma_pending_i(st[0]), .timeout_flag_o(flag),
    .stall_release_n_o(srel_n), .reply_received_o(rrcv), .slip_o(slip),
    .sync_reply_o(syncr), .tx_lo_en_o(got[7]), .tx_hi_en_o(got[6]),
    .rx_lo_en_o(got[5]), .rx_hi_en_o(got[4]),
    .io_page_select_n_o(got[3]), .io_page_select_rx_o(io_rx),
    .intr_req_o(got[2]), .dma_req_o(dreq),
    .intr_ack_chain_out_n_o(got[1]), .dma_grant_chain_out_n_o(got[0]));

  // Slip pulses stand one cycle, so they are counted on every rising edge.
  always @(posedge clk)
    if (slip === 1'b1)
      slips++;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_vec(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Opens a transfer and waits, bounded, for the stall to be released.
  task automatic xact(input logic [7:0] d, input logic mute,
                      input logic wr);
    m_dly = d;
    m_mute = mute;
    slips = 0;
    cyc = 0;
    if (wr)
      wr_req = 1'b1;
    else
      rd_req = 1'b1;
    tick(1);
    while (srel_n !== 1'b0 && cyc < 40)
    begin
      tick(1);
      cyc++;
    end
  endtask

  task automatic drop;
    rd_req = 1'b0;
    wr_req = 1'b0;
    tick(2);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hang is cut off long after the hundred-odd cycles of the run.
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    tick(1);
    chk_bit("reset_srel_n", 1'b1, srel_n);
    chk_bit("reset_flag", 1'b0, flag);
    chk_vec("reset_steer", 8'h0B, got);
    chk_bit("reset_io_rx", 1'b0, io_rx);
    chk_bit("reset_dma_req", 1'b0, dreq);
    tick(1);
    rstn = 1'b1;
    tick(1);
    // Steering table, settled a few cycles after each change.
    foreach (rows[i])
    begin
      st = rows[i][20:8];
      tick(4);
      chk_vec("steer", rows[i][7:0], got);
      chk_bit("rx_hi", rows[i][4], got[4]);
      chk_bit("irq", rows[i][2], got[2]);
      chk_bit("iak_out", rows[i][1], got[1]);
      chk_bit("dma_req", ~rows[i][10], dreq);
      chk_bit("io_rx", ~rows[i][3], io_rx);
    end
    st = 13'h1ECE;
    tick(2);
    // Prompt reply, then a second transfer straight after.
    repeat (2)
    begin
      xact(8'h01, 1'b0, 1'b0);
      chk_bit("prompt_release", 1'b0, srel_n);
      chk_bit("prompt_rrcv", 1'b1, rrcv);
      chk_bit("prompt_flag", 1'b0, flag);
      chk_bit("prompt_fast", 1'b1, cyc <= 4);
      drop();
      chk_bit("idle_srel_n", 1'b1, srel_n);
    end
    // Slow write reply: stalled with slips until the answer comes.
    xact(8'h06, 1'b0, 1'b1);
    chk_bit("slow_waited", 1'b1, cyc >= 4);
    chk_bit("slow_slipped", 1'b1, slips > 0);
    chk_bit("slow_flag", 1'b0, flag);
    drop();
    // Mute slave: the window runs out and the flag holds until cleared.
    xact(8'h00, 1'b1, 1'b0);
    chk_bit("to_flag", 1'b1, flag);
    chk_bit("to_release", 1'b0, srel_n);
    chk_bit("to_window", 1'b1, cyc >= TOC && cyc <= TOC + 2);
    chk_bit("to_rrcv", 1'b0, rrcv);
    drop();
    tick(2);
    chk_bit("to_hold", 1'b1, flag);
    row = 1'b1;
    tick(1);
    row = 1'b0;
    tick(2);
    chk_bit("to_clear", 1'b0, flag);
    // External read: both lanes receive once the reply is synchronised.
    st = 13'h1ACE;
    xact(8'h01, 1'b0, 1'b0);
    tick(2);
    chk_bit("xr_sync", 1'b1, syncr);
    chk_vec("xr_steer", 8'h3B, got);
    drop();
    st = 13'h1ECE;
    // Reset in mid-wait, then the watchdog works again.
    m_mute = 1'b1;
    rd_req = 1'b1;
    tick(3);
    chk_bit("mid_waiting", 1'b1, srel_n);
    rstn = 1'b0;
    tick(1);
    chk_bit("mid_flag", 1'b0, flag);
    chk_bit("mid_srel_n", 1'b1, srel_n);
    rd_req = 1'b0;
    rstn = 1'b1;
    tick(2);
    xact(8'h02, 1'b0, 1'b0);
    chk_bit("after_rrcv", 1'b1, rrcv);
    drop();
    tally_and_finish();
  end
endmodule // testbench
